// *** src/sfr_pkg.sv ***
// shared constants and carriers for the bit-oriented frame receiver
package sfr_pkg;
    localparam logic [15:0] SFR_CRC_INIT = 16'hFFFF; // checker preset at each opening flag
    localparam logic [15:0] SFR_CRC_POLY = 16'h1021; // ccitt polynomial
    localparam logic [15:0] SFR_CRC_GOOD = 16'h1D0F; // residual of an error-free frame
    localparam logic [7:0] SFR_GLOBAL_ADDR = 8'hFF; // broadcast address always accepted
    localparam logic [3:0] SFR_STUFF_ONES = 4'h5; // ones before a stuffed zero
    localparam logic [3:0] SFR_ABORT_ONES = 4'h7; // ones that make an abort
    localparam logic [2:0] SFR_DLY_BITS = 3'h6; // flag bits that enter the data path
    localparam logic [2:0] SFR_VEC_NONE = 3'h0; // vector code: nothing pending
    localparam logic [2:0] SFR_VEC_EXT = 3'h1; // vector code: external/status
    localparam logic [2:0] SFR_VEC_RX = 3'h2; // vector code: first character
    localparam logic [2:0] SFR_VEC_SPECIAL = 3'h3; // vector code: special receive

    // receiver setup, held steady by the host
    typedef struct packed {
        logic rx_en; // receive enable
        logic crc_en; // receive crc enable
        logic addr_search; // compare first field with station address
        logic auto_en; // accept data only while carrier is present
        logic first_int; // receive interrupt on first character only
        logic ext_ie; // external/status interrupt enable
        logic sav; // status affects vector
        logic wr_en; // wait/ready function enable, ready mode
    } sfr_cfg_s;

    // one event passed from the link domain
    typedef struct packed {
        logic eof; // closing flag seen
        logic first; // first byte of the frame
        logic crc_ok; // residual matched at closing flag
        logic [2:0] residue; // bits left over at closing flag
        logic [7:0] data; // received byte
    } sfr_ev_s;

    // line status register view
    typedef struct packed {
        logic abort; // break/abort latched
        logic dcd; // carrier detect latched
        logic rx_avail; // receive character available
    } sfr_lstat_s;

    // receive condition register view
    typedef struct packed {
        logic eof; // end of frame
        logic crc_err; // crc error
        logic overrun; // receive overrun
        logic [2:0] residue; // residue code
    } sfr_rcond_s;
endpackage

// *** src/sfr_frame_receiver.sv ***
// frame receiver channel: link-side deframer plus host/dma side
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: flags found by programmed flag pattern
// R2: address search compares first field to station
// R3: interrupt only after flag and matching address
// R4: first-char mode interrupts for address only
// R5: arm command re-enables next first-char interrupt
// R6: host rewrites receiver control to start
// R7: host reads address, enables dma and ready
// R8: dma moves one byte per ready
// R9: carrier or abort change raises external interrupt
// R10: overrun raises special receive interrupt
// R11: closing flag interrupts and stops ready
// R12: residue bits given at end of frame
// R13: host reads condition, crc and residue
// R14: error reset clears special condition latches
// R15: seven or more ones declare abort
// R16: host answers abort with external reset
// R17: end of ones run clears abort, interrupts
// R18: status affects vector only on channel b
// R19: crc good only on residual 1D0F
// R20: ready held while unread character waits
// R21: disabled receiver ignores the serial input; abort is still detected and still raises external status
module sfr_frame_receiver #(
    parameter bit IS_CHAN_B = 1'b1 // second channel owns vector modification
) (
    input wire logic core_clk_i, // system clock, 25 MHz
    input wire logic link_clk_i, // receive bit clock from the line
    input wire logic sys_rst_i, // async reset, active high
    input wire logic ce_i, // core clock enable
    input wire logic rx_bit_i, // serial data, link clock domain
    input wire logic dcd_i, // carrier detect pin
    input wire sfr_pkg::sfr_cfg_s cfg_i, // receiver setup
    input wire logic [7:0] station_addr_i, // station address register
    input wire logic [7:0] flag_pattern_i, // flag pattern register
    input wire logic cmd_arm_first_i, // pulse: enable interrupt on next first character
    input wire logic cmd_err_reset_i, // pulse: error reset
    input wire logic cmd_ext_reset_i, // pulse: reset external/status
    input wire logic rd_i, // pulse: receive buffer read
    output logic [7:0] rx_data_o, // receive buffer
    output logic rdy_req_o, // dma ready request
    output logic irq_o, // interrupt request
    output logic [2:0] vec_mod_o, // vector modification code
    output sfr_pkg::sfr_lstat_s line_status_o, // line status
    output sfr_pkg::sfr_rcond_s rcv_cond_o // receive condition
);
    import sfr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link domain state
    typedef struct packed {
        logic en_m; // enable sync, first stage
        logic en_s; // enable sync, second stage
        logic [7:0] pat; // local copy of the flag pattern
        logic [7:0] raw; // last eight line bits, newest on top
        logic [3:0] ones; // run of ones, saturating
        logic abort; // abort level
        logic in_frame; // between opening and closing flag
        logic [5:0] dly; // destuffed bits held back from the flag
        logic [2:0] dcnt; // bits held in dly
        logic [7:0] asmb; // byte assembly
        logic [2:0] acnt; // bits in asmb
        logic first; // next byte is the first
        logic [15:0] crc; // running check
        sfr_ev_s ev; // last event
        logic ev_tgl; // flips once per event
    } sfr_link_s;

    typedef struct packed {
        logic [7:0] pat; // flag pattern, captured while disabled
        logic tg_m, tg_s, tg_d; // event toggle sync and edge
        logic dcd_m, dcd_s; // carrier sync
        logic ab_m, ab_s; // abort sync
        logic dcd_l, ab_l; // latched external status
        logic ext_pend; // external/status pending
        logic armed; // first-character interrupt armed
        logic accept; // current frame passed address search
        logic rx_pend; // first-character interrupt pending
        logic [7:0] buf_q; // receive buffer
        logic full; // buffer holds an unread character
        logic wr_on; // wait/ready active
        logic wr_en_d; // previous wait/ready enable
        logic eof; // end of frame latched
        logic crc_err; // crc error latched
        logic ovr; // overrun latched
        logic [2:0] res; // residue latched
        logic sp_pend; // special receive pending
    } sfr_core_s;

    sfr_link_s l_r, l_nxt;
    sfr_core_s c_r, c_nxt;

    // one bit of the frame check
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? SFR_CRC_POLY : 16'h0000);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side: flag hunt, zero deletion, abort, byte assembly
    // six bits wait in dly so the closing flag's own bits never reach the check
    always_comb begin
        logic b;
        logic flag;
        logic ob;
        b = rx_bit_i;
        ob = 1'b0;
        flag = 1'b0;
        l_nxt = l_r;
        l_nxt.en_m = c_r.pat != 8'h00 ? cfg_i.rx_en : 1'b0;
        l_nxt.en_s = l_r.en_m;
        if (!l_r.en_s) begin
            l_nxt.pat = c_r.pat; // core changes it only while disabled
        end
        l_nxt.raw = {b, l_r.raw[7:1]};
        flag = l_nxt.raw == l_r.pat; // R1
        l_nxt.ones = b ? ((l_r.ones == 4'hF) ? l_r.ones : l_r.ones + 4'h1) : 4'h0;
        l_nxt.abort = l_nxt.ones >= SFR_ABORT_ONES; // R15 R17
        if (!l_r.en_s) begin
            l_nxt.in_frame = 1'b0; // R21
        end else if (l_nxt.abort) begin
            l_nxt.in_frame = 1'b0; // frame dropped, hunt again
        end else if (flag) begin
            if (l_r.in_frame && !l_r.first) begin
                l_nxt.ev = '{eof: 1'b1, first: 1'b0, crc_ok: l_r.crc == SFR_CRC_GOOD, // R19
                             residue: l_r.acnt, data: 8'h00}; // R12
                l_nxt.ev_tgl = !l_r.ev_tgl;
            end
            l_nxt.in_frame = 1'b1;
            l_nxt.first = 1'b1;
            l_nxt.crc = SFR_CRC_INIT;
            l_nxt.dcnt = 3'h0;
            l_nxt.acnt = 3'h0;
        end else if (l_r.in_frame && !(l_r.ones == SFR_STUFF_ONES && !b)
                     && !(b && l_r.ones >= SFR_STUFF_ONES)) begin
            // plain data bit: delay it past any flag that may follow
            l_nxt.dly = {b, l_r.dly[5:1]};
            if (l_r.dcnt == SFR_DLY_BITS) begin
                ob = l_r.dly[0];
                l_nxt.crc = crc_step(l_r.crc, ob);
                l_nxt.asmb = {ob, l_r.asmb[7:1]};
                l_nxt.acnt = l_r.acnt + 3'h1;
                if (l_r.acnt == 3'h7) begin
                    l_nxt.ev = '{eof: 1'b0, first: l_r.first, crc_ok: 1'b0,
                                 residue: 3'h0, data: {ob, l_r.asmb[7:1]}};
                    l_nxt.ev_tgl = !l_r.ev_tgl;
                    l_nxt.first = 1'b0;
                end
            end else begin
                l_nxt.dcnt = l_r.dcnt + 3'h1;
            end
        end
    end

    // link register
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core side: address search, buffer, status and interrupts
    always_comb begin
        logic ev_v;
        logic byte_in;
        logic match;
        sfr_ev_s ev;
        ev = l_r.ev; // stable for many core cycles after the toggle
        ev_v = 1'b0;
        match = 1'b0;
        byte_in = 1'b0;
        c_nxt = c_r;
        c_nxt.tg_m = l_r.ev_tgl;
        c_nxt.tg_s = c_r.tg_m;
        c_nxt.tg_d = c_r.tg_s;
        c_nxt.dcd_m = dcd_i;
        c_nxt.dcd_s = c_r.dcd_m;
        c_nxt.ab_m = l_r.abort;
        c_nxt.ab_s = c_r.ab_m;
        if (!cfg_i.rx_en) begin
            c_nxt.pat = flag_pattern_i;
        end
        // a toggle edge marks a new record; the record stands two link bits at least
        ev_v = (c_r.tg_s != c_r.tg_d) && cfg_i.rx_en // R21
               && !(cfg_i.auto_en && !c_r.dcd_s);
        match = !cfg_i.addr_search || ev.data == station_addr_i
                || ev.data == SFR_GLOBAL_ADDR; // R2
        // external/status: latch on change, hold until reset
        if (cmd_ext_reset_i) begin
            c_nxt.ext_pend = 1'b0;
        end
        if (!c_r.ext_pend && (c_r.dcd_s != c_r.dcd_l || c_r.ab_s != c_r.ab_l)) begin
            c_nxt.ext_pend = 1'b1; // R9 R17
            c_nxt.dcd_l = c_r.dcd_s;
            c_nxt.ab_l = c_r.ab_s;
        end
        if (cmd_arm_first_i) begin
            c_nxt.armed = 1'b1; // R5
        end
        if (rd_i) begin
            c_nxt.full = 1'b0;
            c_nxt.rx_pend = 1'b0;
        end
        if (cfg_i.wr_en && !c_r.wr_en_d) begin
            c_nxt.wr_on = 1'b1;
        end
        if (!cfg_i.wr_en) begin
            c_nxt.wr_on = 1'b0;
        end
        c_nxt.wr_en_d = cfg_i.wr_en;
        if (cmd_err_reset_i) begin
            c_nxt.eof = 1'b0; // R14
            c_nxt.crc_err = 1'b0;
            c_nxt.ovr = 1'b0;
            c_nxt.sp_pend = 1'b0;
        end
        byte_in = 1'b0;
        if (ev_v && !ev.eof && ev.first) begin
            c_nxt.accept = match;
            byte_in = match;
            if (match && c_r.armed && cfg_i.first_int) begin
                c_nxt.rx_pend = 1'b1; // R3 R4
                c_nxt.armed = 1'b0;
            end
        end else if (ev_v && !ev.eof) begin
            byte_in = c_r.accept;
        end
        if (byte_in) begin
            c_nxt.buf_q = ev.data;
            c_nxt.full = 1'b1;
            if (c_r.full && !rd_i) begin
                c_nxt.ovr = 1'b1; // R10
                c_nxt.sp_pend = 1'b1;
            end
        end
        if (ev_v && ev.eof && c_r.accept) begin
            c_nxt.accept = 1'b0;
            c_nxt.eof = 1'b1; // R11
            c_nxt.sp_pend = 1'b1;
            c_nxt.wr_on = 1'b0; // R11
            c_nxt.crc_err = cfg_i.crc_en && !ev.crc_ok; // R19
            c_nxt.res = ev.residue; // R12
        end
    end

    // core register, frozen while the clock enable is low
    // the link side keeps running meanwhile, so no frame should arrive then
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c_r <= '0;
        end else if (ce_i) begin
            c_r <= c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rx_data_o = c_r.buf_q;
    assign rdy_req_o = c_r.wr_on && c_r.full; // R20
    assign line_status_o = '{abort: c_r.ab_l, dcd: c_r.dcd_l, rx_avail: c_r.full};
    assign rcv_cond_o = '{eof: c_r.eof, crc_err: c_r.crc_err, overrun: c_r.ovr,
                          residue: c_r.res};
    assign irq_o = (c_r.ext_pend && cfg_i.ext_ie) || c_r.rx_pend || c_r.sp_pend;

    // vector modification, highest priority first
    always_comb begin
        vec_mod_o = SFR_VEC_NONE;
        if (IS_CHAN_B && cfg_i.sav) begin // R18
            if (c_r.sp_pend) begin
                vec_mod_o = SFR_VEC_SPECIAL;
            end else if (c_r.rx_pend) begin
                vec_mod_o = SFR_VEC_RX;
            end else if (c_r.ext_pend && cfg_i.ext_ie) begin
                vec_mod_o = SFR_VEC_EXT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // core domain: outputs and latches
    a_ready_needs_data: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R20
        rdy_req_o |-> line_status_o.rx_avail) else $error("ready without data");
    a_eof_stops_ready: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R11
        ce_i && c_nxt.eof && !c_r.eof |=> !rdy_req_o && irq_o)
        else $error("end of frame left ready on");
    a_err_reset_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R14
        ce_i && cmd_err_reset_i && !c_nxt.sp_pend |=> !rcv_cond_o.eof && !rcv_cond_o.overrun)
        else $error("error reset ignored");
    a_overrun_special: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R10
        ce_i && c_nxt.ovr && !c_r.ovr |=> rcv_cond_o.overrun && irq_o)
        else $error("overrun without special condition");
    a_first_needs_arm: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R4
        $rose(c_r.rx_pend) |-> $past(c_r.armed) && !c_r.armed)
        else $error("first character interrupt while unarmed");
    a_arm_rearms: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R5
        ce_i && cmd_arm_first_i |=> c_r.armed || c_r.rx_pend)
        else $error("arm command lost");
    a_dcd_change_ext: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R9
        ce_i && !c_r.ext_pend && c_r.dcd_s != c_r.dcd_l |=> c_r.ext_pend)
        else $error("carrier change missed");
    a_vec_chan_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R18
        !IS_CHAN_B |-> vec_mod_o == SFR_VEC_NONE) else $error("vector changed on channel a");
    a_abort_ext: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R9 R17
        ce_i && !c_r.ext_pend && c_r.ab_s != c_r.ab_l |=> c_r.ext_pend)
        else $error("abort change missed");
    a_ready_follows_en: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // R20
        ce_i && !cfg_i.wr_en |=> !rdy_req_o)
        else $error("ready without wait/ready enable");
    a_ce_freezes: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !ce_i |=> $stable(c_r))
        else $error("core state moved while clock enable low");

    // link domain: flag hunt and abort
    a_flag_opens: assert property (@(posedge link_clk_i) disable iff (sys_rst_i) // R1
        l_r.en_s && !l_nxt.abort && l_nxt.raw == l_r.pat |=> l_r.in_frame && l_r.first)
        else $error("flag not recognised");
    a_abort_seven_ones: assert property (@(posedge link_clk_i) disable iff (sys_rst_i) // R15
        l_r.ones >= SFR_ABORT_ONES |-> l_r.abort && !l_r.in_frame)
        else $error("abort not declared");
    a_disabled_hunts: assert property (@(posedge link_clk_i) disable iff (sys_rst_i) // R21
        !l_r.en_s |=> !l_r.in_frame) else $error("frame kept while disabled");

    // main scenarios reached
    c_first_int: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(c_r.rx_pend));
    c_end_frame: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(c_r.eof));
    c_abort_seen: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(c_r.ab_l));
    c_overrun: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(c_r.ovr));
    c_dma_move: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        rdy_req_o && rd_i);
endmodule

`default_nettype wire

// *** testbench/sfr_station_model.sv ***
// remote frame station and dma controller model for the frame receiver bench
`timescale 1ns/1ps
`default_nettype none
module sfr_station_model (
    input wire logic core_clk_i, // system clock
    input wire logic rdy_req_i, // dma ready request
    input wire logic [7:0] data_i, // receive buffer
    input wire logic slow_i, // stall the dma now and then
    output logic link_clk_o, // bit clock, still between frames
    output logic rx_bit_o, // serial data to the receiver
    output logic dma_rd_o // dma read strobe
);
    import sfr_pkg::*;
    localparam logic [7:0] FLAG = 8'h7E; // opening and closing flag
    logic [7:0] dma_q[$]; // bytes moved to memory
    int ones; // ones since the last zero
    logic [15:0] crc; // running check value
    logic go, held; // dma decision now, and a stall already taken

    // quiet line and idle dma at time zero
    initial begin
        link_clk_o = 1'b0;
        rx_bit_o = 1'b0;
        dma_rd_o = 1'b0;
        held = 1'b0;
        ones = 0;
        crc = SFR_CRC_INIT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one bit on the line, data set half a bit ahead of the rising edge
    task automatic bit_out(input logic b);
        rx_bit_o = b;
        #32 link_clk_o = 1'b1;
        #32 link_clk_o = 1'b0;
    endtask

    // data bit with check update and zero insertion
    task automatic dbit(input logic b);
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? SFR_CRC_POLY : 16'h0000);
        bit_out(b);
        ones = b ? ones + 1 : 0;
        if (ones == 5) begin
            bit_out(1'b0); // stuffed zero
            ones = 0;
        end
    endtask

    // flag sent unstuffed, lsb first
    task automatic flag();
        for (int i = 0; i < 8; i++)
            bit_out(FLAG[i]);
        ones = 0;
    endtask

    // run of ones after a flag, clock then stands still
    task automatic ones_run(input int n);
        flag();
        for (int i = 0; i < n; i++)
            bit_out(1'b1);
    endtask

    // whole frame: fields, leftover bits, complemented check sequence
    task automatic frame(input logic [7:0] q[$], input int k, input logic bad);
        logic [15:0] fcs;
        #7;
        flag();
        flag();
        crc = SFR_CRC_INIT;
        foreach (q[i])
            for (int j = 0; j < 8; j++)
                dbit(q[i][j]);
        for (int j = 0; j < k; j++)
            dbit(j[0]);
        fcs = ~crc ^ {15'h0000, bad}; // bad spoils the last check bit
        for (int j = 15; j >= 0; j--)
            dbit(fcs[j]);
        flag();
        flag();
        rx_bit_o = ~rx_bit_o; // released line shows no stale level
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one byte moved per ready request; a stall lasts one cycle at most, so the
    // last byte is still taken before the closing flag drops the request
    always @(posedge core_clk_i) begin
        if (dma_rd_o)
            dma_q.push_back(data_i);
        go = rdy_req_i & ~dma_rd_o & (~slow_i | held | ($urandom_range(1) == 0));
        held <= rdy_req_i & ~dma_rd_o & ~go;
        dma_rd_o <= go;
    end
endmodule
`default_nettype wire

// *** testbench/sfr_frame_receiver_test.sv ***
// self-checking bench for the frame receiver channel
`timescale 1ns/1ps
`default_nettype none
module sfr_frame_receiver_test;
    import sfr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dcd = 1'b0;
    logic arm = 1'b0;
    logic errr = 1'b0;
    logic extr = 1'b0;
    logic hrd = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic saw_rx = 1'b0;
    logic [7:0] sta = 8'h00;
    logic [7:0] q[$];
    int k;
    int n_errors = 0;
    int cmp_count = 0;
    sfr_cfg_s cfg = '0;
    wire logic lclk, rbit, drd, rdy, irq;
    wire logic [7:0] rdata;
    wire logic [2:0] vec, vec_a;
    wire sfr_lstat_s ls;
    wire sfr_rcond_s rc;

    sfr_frame_receiver uut (.core_clk_i(clk), .link_clk_i(lclk), .sys_rst_i(rst), .ce_i(ce),
        .rx_bit_i(rbit), .dcd_i(dcd), .cfg_i(cfg), .station_addr_i(sta), .flag_pattern_i(8'h7E),
        .cmd_arm_first_i(arm), .cmd_err_reset_i(errr), .cmd_ext_reset_i(extr), .rd_i(hrd | drd),
        .rx_data_o(rdata), .rdy_req_o(rdy), .irq_o(irq), .vec_mod_o(vec), .line_status_o(ls),
        .rcv_cond_o(rc));
    sfr_station_model peer (.core_clk_i(clk), .rdy_req_i(rdy), .data_i(rdata), .slow_i(slow),
        .link_clk_o(lclk), .rx_bit_o(rbit), .dma_rd_o(drd));
    // channel a copy on the same stimulus except the dma reads (host reads only): vector modification must stay off
    sfr_frame_receiver #(.IS_CHAN_B(1'b0)) uut_a (.core_clk_i(clk), .link_clk_i(lclk),
        .sys_rst_i(rst), .ce_i(ce), .rx_bit_i(rbit), .dcd_i(dcd), .cfg_i(cfg),
        .station_addr_i(sta), .flag_pattern_i(8'h7E), .cmd_arm_first_i(arm),
        .cmd_err_reset_i(errr), .cmd_ext_reset_i(extr), .rd_i(hrd), .rx_data_o(),
        .rdy_req_o(), .irq_o(), .vec_mod_o(vec_a), .line_status_o(), .rcv_cond_o());

    // core clock and first-character interrupt monitor
    initial forever #20 clk = ~clk;
    always @(negedge clk) if (irq === 1'b1 && vec === SFR_VEC_RX) saw_rx = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one-cycle command: 0 arm, 1 error reset, 2 external reset, 3 read
    task automatic pulse(input int w);
        @(posedge clk);
        case (w)
            0: arm <= 1'b1;
            1: errr <= 1'b1;
            2: extr <= 1'b1;
            default: hrd <= 1'b1;
        endcase
        @(posedge clk);
        {arm, errr, extr, hrd} <= 4'h0;
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 400 && irq !== 1'b1; i++)
            @(negedge clk);
        if (i == 400) begin
            n_errors++;
            end_sim();
        end
    endtask

    // random frame; the host takes the address and starts the dma when asked
    task automatic run_frame(input logic [7:0] a, input logic bad, input logic host);
        int n;
        n = $urandom_range(2, 5);
        k = $urandom_range(0, 7);
        q = {a};
        repeat (n) q.push_back(8'($urandom));
        peer.dma_q.delete();
        saw_rx = 1'b0;
        fork
            peer.frame(q, k, bad);
            if (host) begin
                wait_irq();
                chk("first vec", 8'(vec), 8'(SFR_VEC_RX));
                chk("address", rdata, a);
                pulse(3);
                @(posedge clk);
                cfg.wr_en <= 1'b1;
            end
        join
        idle(8);
    endtask

    // host leaves dma mode and clears the special condition
    task automatic end_frame();
        @(posedge clk);
        cfg.wr_en <= 1'b0;
        pulse(1);
        idle(2);
        chk("eof clr", 8'(rc.eof), 8'h00);
        chk("irq clr", 8'(irq), 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(9));
        sta = 8'(16 + $urandom_range(0, 95));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        chk("irq rst", 8'(irq), 8'h00);
        chk("cond rst", 8'(rc), 8'h00);
        chk("status rst", 8'(ls), 8'h00);
        @(posedge clk);
        dcd <= 1'b1;
        ce <= 1'b0;
        cfg <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        @(posedge clk);
        cfg.rx_en <= 1'b1;
        idle(6);
        chk("frozen irq", 8'(irq), 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        idle(6);
        chk("ext irq", 8'(irq), 8'h01);
        chk("ext vec", 8'(vec), 8'(SFR_VEC_EXT));
        chk("chan a vec", 8'(vec_a), 8'h00);
        chk("dcd", 8'(ls.dcd), 8'h01);
        pulse(2);
        idle(3);
        chk("ext clr", 8'(irq), 8'h00);
        $display("test carrier done");
        slow <= 1'b1;
        pulse(0);
        run_frame(sta, 1'b0, 1'b1);
        chk("eof", 8'(rc.eof), 8'h01);
        chk("crc", 8'(rc.crc_err), 8'h00);
        chk("residue", 8'(rc.residue), 8'(k));
        chk("ready off", 8'(rdy), 8'h00);
        chk("eof vec", 8'(vec), 8'(SFR_VEC_SPECIAL));
        chk("dma count", 8'(peer.dma_q.size()), 8'(q.size() + 1));
        for (int i = 0; i + 1 < q.size(); i++)
            chk("dma byte", peer.dma_q[i], q[i + 1]);
        end_frame();
        $display("test dma frame done");
        run_frame(sta, 1'b0, 1'b0);
        chk("no rearm", 8'(saw_rx), 8'h00);
        chk("overrun", 8'(rc.overrun), 8'h01);
        chk("ovr vec", 8'(vec), 8'(SFR_VEC_SPECIAL));
        pulse(3);
        end_frame();
        $display("test overrun done");
        slow <= 1'b0;
        pulse(0);
        run_frame(SFR_GLOBAL_ADDR, 1'b1, 1'b1);
        chk("rearm", 8'(saw_rx), 8'h01);
        chk("crc bad", 8'(rc.crc_err), 8'h01);
        chk("eof bad", 8'(rc.eof), 8'h01);
        end_frame();
        $display("test crc error done");
        pulse(0);
        run_frame(~sta, 1'b0, 1'b0);
        chk("foreign", 8'(saw_rx), 8'h00);
        chk("foreign eof", 8'(rc.eof), 8'h00);
        @(posedge clk);
        cfg.rx_en <= 1'b0;
        run_frame(sta, 1'b0, 1'b0);
        chk("off eof", 8'(rc.eof), 8'h00);
        chk("off avail", 8'(ls.rx_avail), 8'h00);
        $display("test ignored frames done");
        @(posedge clk);
        cfg.rx_en <= 1'b1;
        cfg.sav <= 1'b0;
        peer.ones_run(8);
        idle(8);
        chk("abort", 8'(ls.abort), 8'h01);
        chk("abort irq", 8'(irq), 8'h01);
        chk("plain vec", 8'(vec), 8'h00);
        pulse(2);
        idle(3);
        chk("abort held", 8'(irq), 8'h00);
        peer.flag();
        peer.flag();
        idle(8);
        chk("abort end", 8'(ls.abort), 8'h00);
        chk("second irq", 8'(irq), 8'h01);
        pulse(2);
        idle(3);
        chk("second clr", 8'(irq), 8'h00);
        $display("test abort done");
        end_sim();
    end
endmodule
`default_nettype wire
